// [common/ihb_pkg.sv]
// Shared constants and types for the indicator heartbeat and target block
package ihb_pkg;
    // ************************************************************
    // Object indices
    // ************************************************************
    localparam logic [15:0] IHB_IDX_HB   = 16'h5F09;
    localparam logic [15:0] IHB_IDX_NODE = 16'h5F0A;
    localparam logic [15:0] IHB_IDX_CTRL = 16'h5F0C;
    localparam logic [15:0] IHB_IDX_WIN  = 16'h5F10;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] IHB_HB_RST   = 16'h012C;
    localparam logic [6:0]  IHB_NODE_RST = 7'h00;
    localparam logic [7:0]  IHB_CTRL_RST = 8'h00;
    localparam logic [31:0] IHB_WIN_RST  = 32'h0000_0005;

    // ************************************************************
    // Field positions and legal values
    // ************************************************************
    localparam int          IHB_CTRL_VALID = 0;
    localparam int          IHB_CTRL_BLINK = 1;
    localparam int          IHB_CTRL_GREEN = 4;
    localparam int          IHB_CTRL_RED   = 5;
    localparam logic [7:0]  IHB_CTRL_MASK  = 8'h33;
    localparam int          IHB_CFG_GREEN  = 4;
    localparam int          IHB_CFG_RED    = 5;
    localparam logic [7:0]  IHB_NODE_MIN   = 8'h01;
    localparam logic [7:0]  IHB_NODE_MAX   = 8'h7F;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int IHB_CLK_NS    = 40;
    localparam int IHB_TICK_MS   = 1;
    localparam int IHB_MS_CYCLES = IHB_TICK_MS * 1000000 / IHB_CLK_NS;
    localparam int IHB_BLINK_MS  = 250;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        IHB_INIT, IHB_PREOP, IHB_OP, IHB_STOP
    } ihb_comm_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        pdo;
        logic [15:0] index;
        logic [31:0] wdata;
    } ihb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } ihb_rsp_t;

    typedef struct packed {
        logic [15:0] hb_int;
        logic [15:0] hb_cnt;
        logic [15:0] pre;
        logic [15:0] blink_cnt;
        logic        blink_ph;
        logic [6:0]  node_st;
        logic [6:0]  node_act;
        logic [7:0]  ctrl;
        logic [31:0] win;
        logic [1:0]  cfg_last;
        logic        achieved;
        logic        drop;
        logic        green;
        logic        red;
        ihb_rsp_t    rsp;
    } ihb_state_t;
endpackage : ihb_pkg

// [rtl/ihb_core.sv]
// Heartbeat supervision, node id, control byte and target window logic
`timescale 1ns/1ns

// What this block does
// - A nonzero interval without an event in Operational drops to Pre-Operational.
// - The interval counts whole milliseconds and may be set from 0 to 65535.
// - An interval of zero turns the supervision off entirely.
// - Interval, control and window writes pass in Pre-Op and Operational.
// - A node id of 1 to 127 is stored and only used after re-initialisation.
// - The control byte is write-only and reached only by process data.
// - Control bit 0 marks the target value valid.
// - Control bit 1 makes lit LEDs blink, otherwise they are steady.
// - Control bit 4 forces the green LED on, otherwise it is off.
// - Control bit 5 forces the red LED on, otherwise it is off.
// - Forced LEDs only act while the LED config low two bits are zero.
// - The config object LED settings are copied into control bits 4, 5.
// - Target achieved means position lies within the window of target.
module ihb_core
    import ihb_pkg::*;
#(
    parameter int MS_CYCLES = IHB_MS_CYCLES,
    parameter int BLINK_MS  = IHB_BLINK_MS
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire ihb_req_t    req,
    output ihb_rsp_t         rsp,
    input  wire ihb_comm_t   comm_state,
    input  wire logic        hb_event,
    input  wire logic        comm_reinit,
    input  wire logic [31:0] position,
    input  wire logic [31:0] target,
    input  wire logic [31:0] led_cfg,
    output logic             drop_to_preop,
    output logic [6:0]       active_node_id,
    output logic             target_achieved,
    output logic             led_green,
    output logic             led_red
);

    // ************************************************************
    // State
    // ************************************************************
    ihb_state_t s_r;
    ihb_state_t s_nxt;

    logic        wr_ok;
    logic        tick;
    logic        led_mode0;
    logic        lit_phase;
    logic [32:0] diff;
    logic [32:0] absdiff;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.drop    = 1'b0;
        s_nxt.rsp.ack = 1'b0;
        s_nxt.rsp.err = 1'b0;
        wr_ok     = (comm_state == IHB_PREOP) || (comm_state == IHB_OP);
        tick      = (s_r.pre == 16'(MS_CYCLES - 1));
        led_mode0 = (led_cfg[1:0] == 2'b00);

        // Millisecond prescaler
        s_nxt.pre = tick ? 16'h0000 : s_r.pre + 16'h0001;

        // Event wins over expiry in the same cycle, so no false drop
        if (s_r.hb_int == 16'h0000 || comm_state != IHB_OP
            || hb_event) begin
            s_nxt.hb_cnt = 16'h0000;
        end else if (tick) begin
            if (s_r.hb_cnt + 16'h0001 >= s_r.hb_int) begin
                s_nxt.drop   = 1'b1;
                s_nxt.hb_cnt = 16'h0000;
            end else begin
                s_nxt.hb_cnt = s_r.hb_cnt + 16'h0001;
            end
        end

        // Blink phase, in milliseconds
        if (tick) begin
            if (s_r.blink_cnt == 16'(BLINK_MS - 1)) begin
                s_nxt.blink_cnt = 16'h0000;
                s_nxt.blink_ph  = ~s_r.blink_ph;
            end else begin
                s_nxt.blink_cnt = s_r.blink_cnt + 16'h0001;
            end
        end

        // Configuration LED bits copied on change; a same-cycle PDO wins
        if (led_cfg[IHB_CFG_RED:IHB_CFG_GREEN] != s_r.cfg_last) begin
            s_nxt.cfg_last = led_cfg[IHB_CFG_RED:IHB_CFG_GREEN];
            s_nxt.ctrl[IHB_CTRL_RED:IHB_CTRL_GREEN] =
                led_cfg[IHB_CFG_RED:IHB_CFG_GREEN];
        end

        // Stored id moves to the live one only on re-initialisation
        if (comm_reinit) begin
            s_nxt.node_act = s_r.node_st;
        end

        // Object access
        if (req.wr || req.rd) begin
            s_nxt.rsp.ack   = 1'b1;
            s_nxt.rsp.rdata = 32'h0000_0000;
            if (req.index == IHB_IDX_HB) begin
                if (req.rd) begin
                    s_nxt.rsp.rdata = {16'h0000, s_r.hb_int};
                end else if (wr_ok) begin
                    s_nxt.hb_int = req.wdata[15:0];
                    s_nxt.hb_cnt = 16'h0000;
                end else begin
                    s_nxt.rsp.err = 1'b1;
                end
            end else if (req.index == IHB_IDX_NODE) begin
                if (req.rd) begin
                    s_nxt.rsp.rdata = {25'h000_0000, s_r.node_st};
                end else if (wr_ok && req.wdata >= 32'(IHB_NODE_MIN)
                             && req.wdata <= 32'(IHB_NODE_MAX)) begin
                    s_nxt.node_st = req.wdata[6:0];
                end else begin
                    s_nxt.rsp.err = 1'b1;
                end
            end else if (req.index == IHB_IDX_CTRL) begin
                if (req.wr && req.pdo && wr_ok) begin
                    s_nxt.ctrl = req.wdata[7:0] & IHB_CTRL_MASK;
                end else begin
                    s_nxt.rsp.err = 1'b1;
                end
            end else if (req.index == IHB_IDX_WIN) begin
                if (req.rd) begin
                    s_nxt.rsp.rdata = s_r.win;
                end else if (wr_ok) begin
                    s_nxt.win = req.wdata;
                end else begin
                    s_nxt.rsp.err = 1'b1;
                end
            end else begin
                s_nxt.rsp.err = 1'b1;
            end
        end

        // Signed 33-bit difference keeps wrap-around out of the window test
        diff    = {position[31], position} - {target[31], target};
        absdiff = diff[32] ? (33'h0_0000_0000 - diff) : diff;
        s_nxt.achieved = s_r.ctrl[IHB_CTRL_VALID]
                         && (absdiff <= {1'b0, s_r.win});

        // Forced LEDs, optionally blinking
        lit_phase   = !s_r.ctrl[IHB_CTRL_BLINK] || s_r.blink_ph;
        s_nxt.green = led_mode0 && s_r.ctrl[IHB_CTRL_GREEN]
                      && lit_phase;
        s_nxt.red   = led_mode0 && s_r.ctrl[IHB_CTRL_RED]
                      && lit_phase;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{hb_int: IHB_HB_RST, node_st: IHB_NODE_RST,
                     node_act: IHB_NODE_RST, ctrl: IHB_CTRL_RST,
                     win: IHB_WIN_RST, default: '0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rsp             = s_r.rsp;
    assign drop_to_preop   = s_r.drop;
    assign active_node_id  = s_r.node_act;
    assign target_achieved = s_r.achieved;
    assign led_green       = s_r.green;
    assign led_red         = s_r.red;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_hb_drop;
        drop_to_preop |-> $past(s_r.hb_int) != 16'h0000
                          && $past(comm_state) == IHB_OP;
    endproperty
    a_hb_drop: assert property (p_hb_drop)
        else $error("Drop without armed supervision in Operational");

    property p_ms_pre;
        s_r.pre < 16'(MS_CYCLES) && s_r.hb_cnt <= s_r.hb_int;
    endproperty
    a_ms_pre: assert property (p_ms_pre)
        else $error("Millisecond or interval counter out of range");

    property p_hb_off;
        ce && s_r.hb_int == 16'h0000 |=> !drop_to_preop;
    endproperty
    a_hb_off: assert property (p_hb_off)
        else $error("Drop while supervision is off");

    property p_wr_state;
        ce && req.wr && !(comm_state == IHB_PREOP || comm_state == IHB_OP)
        |=> rsp.ack && rsp.err;
    endproperty
    a_wr_state: assert property (p_wr_state)
        else $error("Write outside allowed states not refused");

    property p_node_late;
        ce && !comm_reinit |=> $stable(active_node_id);
    endproperty
    a_node_late: assert property (p_node_late)
        else $error("Live node id changed without re-initialisation");

    property p_ctrl_sdo;
        ce && (req.wr || req.rd) && req.index == IHB_IDX_CTRL
        && !(req.wr && req.pdo) |=> rsp.err && rsp.rdata == 32'h0000_0000;
    endproperty
    a_ctrl_sdo: assert property (p_ctrl_sdo)
        else $error("Control byte reached outside process data write");

    property p_valid;
        target_achieved |-> $past(s_r.ctrl[IHB_CTRL_VALID]);
    endproperty
    a_valid: assert property (p_valid)
        else $error("Target achieved while target invalid");

    property p_steady;
        ce && led_mode0 && !s_r.ctrl[IHB_CTRL_BLINK]
        && s_r.ctrl[IHB_CTRL_GREEN] |=> led_green;
    endproperty
    a_steady: assert property (p_steady)
        else $error("Steady green LED not lit");

    property p_red;
        ce |=> led_red == ($past(led_mode0) && $past(s_r.ctrl[IHB_CTRL_RED])
                           && ($past(!s_r.ctrl[IHB_CTRL_BLINK])
                               || $past(s_r.blink_ph)));
    endproperty
    a_red: assert property (p_red)
        else $error("Red LED does not follow control byte");

    property p_mode;
        ce && !led_mode0 |=> !led_green && !led_red;
    endproperty
    a_mode: assert property (p_mode)
        else $error("Forced LEDs lit outside mode zero");

    property p_mirror;
        ce && !req.wr && led_cfg[IHB_CFG_RED:IHB_CFG_GREEN] != s_r.cfg_last
        |=> s_r.ctrl[IHB_CTRL_RED:IHB_CTRL_GREEN]
            == $past(led_cfg[IHB_CFG_RED:IHB_CFG_GREEN]);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("LED configuration not copied to control byte");

    property p_window;
        ce && s_r.ctrl[IHB_CTRL_VALID] && position == target
        |=> target_achieved;
    endproperty
    a_window: assert property (p_window)
        else $error("Exact position not reported as achieved");

    property p_ack;
        ce && (req.wr || req.rd) |=> rsp.ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("Object access not acknowledged");

    property p_quiet;
        ce && !req.wr && !req.rd |=> !rsp.ack && !rsp.err;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Answer without a request");

    property p_event;
        ce && hb_event |=> !drop_to_preop;
    endproperty
    a_event: assert property (p_event)
        else $error("Drop in the cycle of a heartbeat event");

    property p_node_range;
        ce && req.wr && req.index == IHB_IDX_NODE
        && (req.wdata < 32'(IHB_NODE_MIN) || req.wdata > 32'(IHB_NODE_MAX))
        |=> rsp.err && s_r.node_st == $past(s_r.node_st);
    endproperty
    a_node_range: assert property (p_node_range)
        else $error("Out of range node id not refused");

    property p_ctrl_pdo;
        ce && req.wr && req.pdo && req.index == IHB_IDX_CTRL && wr_ok
        |=> !rsp.err && s_r.ctrl == ($past(req.wdata[7:0]) & IHB_CTRL_MASK);
    endproperty
    a_ctrl_pdo: assert property (p_ctrl_pdo)
        else $error("Process data write to control byte not taken");

    property p_blink_off;
        ce && s_r.ctrl[IHB_CTRL_BLINK] && !s_r.blink_ph
        |=> !led_green && !led_red;
    endproperty
    a_blink_off: assert property (p_blink_off)
        else $error("Blinking LED lit in its dark phase");

    c_drop:    cover property (drop_to_preop);
    c_achieve: cover property (target_achieved);
    c_blink:   cover property (ce && led_green && s_r.ctrl[IHB_CTRL_BLINK]);
    c_pdo:     cover property (ce && req.wr && req.pdo
                               && req.index == IHB_IDX_CTRL);
    c_reinit:  cover property (ce && comm_reinit
                               && s_r.node_st != s_r.node_act);

endmodule : ihb_core

// [bench/ihb_master.sv]
// Bus master model that issues object accesses to the block
`timescale 1ns/1ns
module ihb_master
    import ihb_pkg::*;
(
    input  wire logic     mclk,
    input  wire ihb_rsp_t rsp,
    output ihb_req_t      req
);
    initial begin
        req = '0;
    end

    // One-edge request, bounded wait for ack, then one idle edge
    task automatic acc(input logic wr, input logic pdo,
                       input logic [15:0] idx, input logic [31:0] d,
                       output ihb_rsp_t r);
        int k;
        req.wr    = wr;
        req.rd    = !wr;
        req.pdo   = pdo;
        req.index = idx;
        req.wdata = d;
        @(posedge mclk);
        #1;
        req.wr    = 1'b0;
        req.rd    = 1'b0;
        req.wdata = ~d; // Stale data must not pass for valid
        r = rsp;
        for (k = 0; k < 3 && r.ack !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
            r = rsp;
        end
        // Idle edge so a following call never retoggles a strobe at once
        @(posedge mclk);
        #1;
    endtask : acc
endmodule : ihb_master

// [bench/indicator_heartbeat_target_objects_bench.sv]
// Self-checking bench for heartbeat, node id, control byte and window
`timescale 1ns/1ns
module indicator_heartbeat_target_objects_bench;
    import ihb_pkg::*;
    logic        mclk, rst_b, hb_event, comm_reinit, drop_to_preop;
    logic        target_achieved, led_green, led_red;
    ihb_comm_t   comm_state;
    ihb_req_t    req;
    ihb_rsp_t    rsp, r;
    logic [31:0] position, target, led_cfg, w, nv[4];
    logic [6:0]  active_node_id;
    logic        ne[4], g0, ce;
    int          n_errors, num_checks, seed, i, k, j;

    ihb_core #(.MS_CYCLES(4), .BLINK_MS(2)) ihb_core_i (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .req(req), .rsp(rsp),
        .comm_state(comm_state), .hb_event(hb_event),
        .comm_reinit(comm_reinit), .position(position), .target(target),
        .led_cfg(led_cfg), .drop_to_preop(drop_to_preop),
        .active_node_id(active_node_id), .target_achieved(target_achieved),
        .led_green(led_green), .led_red(led_red));
    ihb_master ihb_master_i (.mclk(mclk), .rsp(rsp), .req(req));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: value %h, want %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: flag %b, want %b", $time, g, e);
        end
    endtask : chk_bit
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tk
    task automatic acc(input logic wr, input logic pdo,
                       input logic [15:0] x, input logic [31:0] d);
        ihb_master_i.acc(wr, pdo, x, d, r);
        chk_bit(r.ack, 1'b1);
    endtask : acc
    // Absolute distance, 33 bits wide so no wrap can fake a hit
    function automatic logic exp_ach(input logic signed [31:0] p,
                                     input logic signed [31:0] t,
                                     input logic [31:0] wn, input logic v);
        logic signed [32:0] d;
        d = 33'(p) - 33'(t);
        if (d < 0) d = -d;
        return v && (d <= $signed({1'b0, wn}));
    endfunction : exp_ach
    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #(20000 * 40);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h44ae;
        nv = '{32'h0000_0000, 32'h0000_0001, 32'h0000_007F, 32'h0000_0080};
        ne = '{1'b1, 1'b0, 1'b0, 1'b1};
        {rst_b, hb_event, comm_reinit} = 3'b000;
        ce = 1'b1;
        comm_state = IHB_PREOP;
        {position, target, led_cfg} = '0;
        tk(2);
        rst_b = 1'b1;
        acc(0, 0, IHB_IDX_HB, '0);
        chk_val(r.rdata, {16'h0000, IHB_HB_RST});
        acc(0, 0, IHB_IDX_WIN, '0);
        chk_val(r.rdata, IHB_WIN_RST);
        acc(0, 0, 16'h5F0B, '0);
        chk_bit(r.err, 1'b1);
        acc(0, 0, IHB_IDX_CTRL, '0);
        chk_bit(r.err, 1'b1);
        acc(1, 0, IHB_IDX_CTRL, 32'h0000_0001);
        chk_bit(r.err, 1'b1);
        for (i = 0; i < 4; i++) begin
            comm_state = i[0] ? IHB_OP : IHB_PREOP;
            w = $random(seed);
            acc(1, i[1], IHB_IDX_WIN, w);
            chk_bit(r.err, 1'b0);
            acc(0, 0, IHB_IDX_WIN, '0);
            chk_val(r.rdata, w);
        end
        comm_state = IHB_STOP;
        acc(1, 0, IHB_IDX_WIN, 32'h0000_0010);
        chk_bit(r.err, 1'b1);
        acc(0, 0, IHB_IDX_WIN, '0);
        chk_val(r.rdata, w);
        comm_state = IHB_PREOP;
        for (i = 0; i < 4; i++) begin
            acc(1, 0, IHB_IDX_NODE, nv[i]);
            chk_bit(r.err, ne[i]);
        end
        chk_val(32'(active_node_id), '0);
        comm_reinit = 1'b1;
        tk(1);
        comm_reinit = 1'b0;
        tk(1);
        chk_val(32'(active_node_id), 32'h0000_007F);
        acc(0, 0, IHB_IDX_NODE, '0);
        chk_val(r.rdata, 32'h0000_007F);
        // Offsets sweep across both window edges
        acc(1, 0, IHB_IDX_WIN, 32'h0000_0010);
        acc(1, 1, IHB_IDX_CTRL, 32'h0000_0001);
        for (i = 0; i < 41; i++) begin
            position = $random(seed) >>> 2;
            target = position + 32'(i - 20);
            tk(2);
            g0 = exp_ach(position, target, 16, 1);
            chk_bit(target_achieved, g0);
        end
        acc(1, 1, IHB_IDX_CTRL, '0);
        target = position;
        tk(2);
        chk_bit(target_achieved, 1'b0);
        for (i = 0; i < 16; i++) begin
            acc(1, 1, IHB_IDX_CTRL, {26'h0, i[3:2], 4'h0});
            led_cfg = 32'(i[1:0]);
            tk(2);
            chk_bit(led_green, i[2] && i[1:0] == 0);
            chk_bit(led_red, i[3] && i[1:0] == 0);
        end
        led_cfg = 32'h0000_0020;
        tk(2);
        chk_bit(led_red, 1'b1);
        chk_bit(led_green, 1'b0);
        for (i = 0; i < 2; i++) begin
            acc(1, 1, IHB_IDX_CTRL, i ? 32'h0000_0030 : 32'h0000_0032);
            k = 0;
            g0 = led_green;
            repeat (40) begin
                tk(1);
                k += (led_green !== g0);
                g0 = led_green;
            end
            chk_bit(k >= 3, !i);
        end
        comm_state = IHB_OP;
        acc(1, 0, IHB_IDX_HB, 32'h0000_0002);
        for (k = 0; k < 40 && drop_to_preop !== 1'b1; k++) tk(1);
        chk_bit(k >= 4 && k <= 12, 1'b1);
        for (i = 0; i < 3; i++) begin
            if (i == 1) acc(1, 0, IHB_IDX_HB, '0);
            comm_state = (i == 2) ? IHB_PREOP : IHB_OP;
            if (i == 2) acc(1, 0, IHB_IDX_HB, 32'h0000_0002);
            k = 0;
            // In the first pass an event at least every fourth edge keeps the timer fed
            for (j = 0; j < 60; j++) begin
                hb_event = (i == 0) && (j % 4 == 0 || $random(seed) % 3 == 0);
                tk(1);
                k += (drop_to_preop === 1'b1);
            end
            hb_event = 1'b0;
            chk_val(32'(k), '0);
        end
        // Clock enable low freezes the timer even in Operational
        ce = 1'b0;
        comm_state = IHB_OP;
        k = 0;
        repeat (40) begin
            tk(1);
            k += (drop_to_preop === 1'b1);
        end
        chk_val(32'(k), '0);
        ce = 1'b1;
        for (k = 0; k < 40 && drop_to_preop !== 1'b1; k++) tk(1);
        chk_bit(k >= 4 && k <= 12, 1'b1);
        tally_and_finish();
    end
endmodule : indicator_heartbeat_target_objects_bench
